// >>> hdl/sdcr_regs.sv
/*
 string descriptor and charge enable register bank of the hub controller.
 assumes one byte-wide configuration write/read port (eeprom loader or
 smbus slave) and a descriptor engine on the same core clock.
*/
`timescale 1ns/10ps
`default_nettype none
module sdcr_regs
   import sdcr_pkg::*;
#(
   parameter int PORTS = SDCR_PORT_HI
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic cfgWrEn,
   input wire logic cfgRdEn,
   input wire logic [7:0] cfgAddr,
   input wire logic [7:0] cfgWrData,
   output logic [7:0] cfgRdData,
   output logic cfgRdValid,
   input wire logic descStart,
   input wire logic [1:0] descSel,
   input wire logic descReady,
   output logic descValid,
   output logic [7:0] descData,
   output logic descLast,
   output logic descBusy,
   output logic [PORTS-1:0] chargeEnable
);
   initial begin
      if (PORTS < 1 || PORTS > SDCR_PORT_HI) $error("PORTS must be 1 to 4");
   end

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef enum {SDCR_IDLE, SDCR_SEND} sdcr_fsm_e;
   typedef struct packed {
      logic [7:0] makerLen;
      logic [7:0] productLen;
      logic [7:0] serialLen;
      logic [7:0] chargeEn;
      logic [7:0] rdData;
      logic rdValid;
      sdcr_fsm_e fsm;
      logic busy;
      logic [7:0] base;
      logic [7:0] count;
      logic [7:0] total;
      logic valid;
      logic [7:0] data;
      logic last;
   } sdcr_state_s;
   sdcr_state_s st_r;
   sdcr_state_s st_nxt;

   // map an offset to the text store index, flag if inside a text block
   function automatic logic [8:0] text_index(input logic [7:0] ofs);
      if (ofs >= SDCR_MAKER_TEXT_OFS && ofs < SDCR_PRODUCT_TEXT_OFS) begin
         text_index = {1'b1, 8'(ofs - SDCR_MAKER_TEXT_OFS)};
      end else if (ofs >= SDCR_PRODUCT_TEXT_OFS && ofs < SDCR_SERIAL_TEXT_OFS) begin
         text_index = {1'b1, 8'(ofs - SDCR_MAKER_TEXT_OFS)};
      end else if (ofs >= SDCR_SERIAL_TEXT_OFS && ofs < SDCR_CHARGE_EN_OFS) begin
         text_index = {1'b1, 8'(ofs - SDCR_MAKER_TEXT_OFS)};
      end else begin
         text_index = 9'h000;
      end
   endfunction : text_index

   // clamp a stored length to 31 characters
   function automatic logic [7:0] clamp_len(input logic [7:0] len);
      clamp_len = (len > SDCR_MAX_CHARS_B) ? SDCR_MAX_CHARS_B : len;
   endfunction : clamp_len

   logic [8:0] wrMap;
   logic [8:0] rdMap;
   logic [7:0] storeRdA;
   logic [7:0] storeRdB;
   logic [7:0] descIdx;
   logic [7:0] selLen;
   logic [7:0] selBase;

   assign wrMap = text_index(cfgAddr);
   assign rdMap = text_index(cfgAddr);
   assign descIdx = 8'(st_r.base + st_r.count);

   sdcr_text_store #(
      .DEPTH(SDCR_STORE_BYTES)
   ) u_store (
      .ref_clk(ref_clk),
      .wrEn(cfgWrEn && wrMap[8]),
      .wrIdx(wrMap[7:0]),
      .wrData(cfgWrData),
      .rdIdxA(rdMap[7:0]),
      .rdIdxB(descIdx),
      .rdDataA(storeRdA),
      .rdDataB(storeRdB)
   );

   // ---------------------------------------------------------------
   // descriptor selection
   // ---------------------------------------------------------------
   always_comb begin
      unique case (descSel)
         2'h1: begin
            selLen = clamp_len(st_r.productLen);
            selBase = 8'(SDCR_PRODUCT_TEXT_OFS - SDCR_MAKER_TEXT_OFS);
         end
         2'h2: begin
            selLen = clamp_len(st_r.serialLen);
            selBase = 8'(SDCR_SERIAL_TEXT_OFS - SDCR_MAKER_TEXT_OFS);
         end
         default: begin
            selLen = clamp_len(st_r.makerLen);
            selBase = 8'h00;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.rdValid = 1'b0;
      // configuration writes
      if (cfgWrEn) begin
         unique case (cfgAddr)
            SDCR_MAKER_LEN_OFS: st_nxt.makerLen = cfgWrData;
            SDCR_PRODUCT_LEN_OFS: st_nxt.productLen = cfgWrData;
            SDCR_SERIAL_LEN_OFS: st_nxt.serialLen = cfgWrData;
            SDCR_CHARGE_EN_OFS: st_nxt.chargeEn = cfgWrData & SDCR_CHARGE_MASK;
            default: ;
         endcase
      end
      // configuration reads, one cycle later, reserved bits zero
      if (cfgRdEn) begin
         st_nxt.rdValid = 1'b1;
         if (rdMap[8]) begin
            st_nxt.rdData = storeRdA;
         end else begin
            unique case (cfgAddr)
               SDCR_MAKER_LEN_OFS: st_nxt.rdData = st_r.makerLen;
               SDCR_PRODUCT_LEN_OFS: st_nxt.rdData = st_r.productLen;
               SDCR_SERIAL_LEN_OFS: st_nxt.rdData = st_r.serialLen;
               SDCR_CHARGE_EN_OFS: st_nxt.rdData = st_r.chargeEn;
               default: st_nxt.rdData = 8'h00;
            endcase
         end
      end
      // descriptor byte stream, ascending, low byte first
      unique case (st_r.fsm)
         SDCR_IDLE: begin
            if (descStart && selLen != 8'h00) begin
               st_nxt.fsm = SDCR_SEND;
               st_nxt.busy = 1'b1;
               st_nxt.base = selBase;
               st_nxt.count = 8'h00;
               st_nxt.total = 8'({selLen, 1'b0});
            end
         end
         SDCR_SEND: begin
            if (!st_r.valid || descReady) begin
               st_nxt.valid = 1'b1;
               st_nxt.data = storeRdB;
               st_nxt.last = (8'(st_r.count + 8'h01) == st_r.total);
               st_nxt.count = 8'(st_r.count + 8'h01);
               if (8'(st_r.count + 8'h01) == st_r.total) begin
                  st_nxt.fsm = SDCR_IDLE;
                  st_nxt.busy = 1'b0;
               end
            end
         end
      endcase
      if (st_r.valid && descReady && st_r.fsm == SDCR_IDLE) begin
         st_nxt.valid = 1'b0;
         st_nxt.last = 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '{makerLen: SDCR_LEN_RST, productLen: SDCR_LEN_RST,
                   serialLen: SDCR_LEN_RST, chargeEn: SDCR_CHARGE_RST,
                   rdData: 8'h00, rdValid: 1'b0, fsm: SDCR_IDLE, busy: 1'b0, base: 8'h00,
                   count: 8'h00, total: 8'h00, valid: 1'b0, data: 8'h00,
                   last: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from the state register
   assign cfgRdData = st_r.rdData;
   assign cfgRdValid = st_r.rdValid;
   assign descValid = st_r.valid;
   assign descData = st_r.data;
   assign descLast = st_r.last;
   assign descBusy = st_r.busy; // own flop so the output carries no decode
   assign chargeEnable = st_r.chargeEn[PORTS:SDCR_PORT_LO];

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   property p_charge_follow;
      @(posedge ref_clk) disable iff (!rst_b)
      cfgWrEn && cfgAddr == SDCR_CHARGE_EN_OFS |=> chargeEnable == $past(cfgWrData[PORTS:1]);
   endproperty
   a_charge_follow: assert property (p_charge_follow) else $error("charge enable mismatch");

   property p_charge_reserved;
      @(posedge ref_clk) disable iff (!rst_b)
      st_r.chargeEn[0] == 1'b0 && st_r.chargeEn[7:5] == 3'b000;
   endproperty
   a_charge_reserved: assert property (p_charge_reserved) else $error("reserved bit set");

   property p_total_bound;
      @(posedge ref_clk) disable iff (!rst_b)
      descBusy |-> st_r.total <= SDCR_TEXT_BYTES && st_r.count < st_r.total;
   endproperty
   a_total_bound: assert property (p_total_bound) else $error("string too long");

   property p_total_even;
      @(posedge ref_clk) disable iff (!rst_b)
      $rose(descBusy) |-> st_r.total[0] == 1'b0;
   endproperty
   a_total_even: assert property (p_total_even) else $error("odd byte count");

   property p_read_lat;
      @(posedge ref_clk) disable iff (!rst_b)
      cfgRdEn |=> cfgRdValid;
   endproperty
   a_read_lat: assert property (p_read_lat) else $error("read answer missing");

   property p_len_read;
      @(posedge ref_clk) disable iff (!rst_b)
      cfgRdEn && cfgAddr == SDCR_SERIAL_LEN_OFS && !cfgWrEn |=> cfgRdData == st_r.serialLen;
   endproperty
   a_len_read: assert property (p_len_read) else $error("length read wrong");

   sequence s_start;
      descStart && !descBusy && selLen != 8'h00;
   endsequence
   property p_stream_begin;
      @(posedge ref_clk) disable iff (!rst_b)
      s_start |=> descBusy ##1 descValid;
   endproperty
   a_stream_begin: assert property (p_stream_begin) else $error("stream did not begin");

   property p_last_end;
      @(posedge ref_clk) disable iff (!rst_b)
      $rose(descLast) |-> !descBusy;
   endproperty
   a_last_end: assert property (p_last_end) else $error("last before end");

   property p_serial_base;
      @(posedge ref_clk) disable iff (!rst_b)
      (s_start and (descSel == 2'h2)) |=> st_r.base == 8'h7C;
   endproperty
   a_serial_base: assert property (p_serial_base) else $error("serial base wrong");
endmodule : sdcr_regs
`default_nettype wire

// >>> hdl/sdcr_text_store.sv
/*
 byte array holding the three string bodies back to back, 62 bytes each.
 assumes the caller has already mapped a register offset to an index.
*/
`timescale 1ns/10ps
`default_nettype none
module sdcr_text_store
   import sdcr_pkg::*;
#(
   parameter int DEPTH = SDCR_STORE_BYTES
) (
   input wire logic ref_clk,
   input wire logic wrEn,
   input wire logic [7:0] wrIdx,
   input wire logic [7:0] wrData,
   input wire logic [7:0] rdIdxA,
   input wire logic [7:0] rdIdxB,
   output logic [7:0] rdDataA,
   output logic [7:0] rdDataB
);
   // ---------------------------------------------------------------
   // storage, no reset: contents come from configuration
   // ---------------------------------------------------------------
   logic [7:0] mem [DEPTH];

   initial begin
      if (DEPTH < 1 || DEPTH > 256) $error("DEPTH out of range");
   end

   // byte write
   always_ff @(posedge ref_clk) begin
      if (wrEn && wrIdx < DEPTH) begin
         mem[wrIdx] <= wrData;
      end
   end

   // two combinational read ports, out of range reads zero
   assign rdDataA = (rdIdxA < DEPTH) ? mem[rdIdxA] : 8'h00;
   assign rdDataB = (rdIdxB < DEPTH) ? mem[rdIdxB] : 8'h00;
endmodule : sdcr_text_store
`default_nettype wire

// >>> shared/sdcr_pkg.sv
/*
 package of the string descriptor and charge enable register bank:
 offsets, field positions, reset values and sizes.
 assumes byte-wide configuration access on the hub core clock.
*/
package sdcr_pkg;
   // ---------------------------------------------------------------
   // offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] SDCR_MAKER_LEN_OFS = 8'h13;
   localparam logic [7:0] SDCR_PRODUCT_LEN_OFS = 8'h14;
   localparam logic [7:0] SDCR_SERIAL_LEN_OFS = 8'h15;
   localparam logic [7:0] SDCR_MAKER_TEXT_OFS = 8'h16;
   localparam logic [7:0] SDCR_PRODUCT_TEXT_OFS = 8'h54;
   localparam logic [7:0] SDCR_SERIAL_TEXT_OFS = 8'h92;
   localparam logic [7:0] SDCR_CHARGE_EN_OFS = 8'hD0;
   // ---------------------------------------------------------------
   // sizes and fields
   // ---------------------------------------------------------------
   localparam int SDCR_MAX_CHARS = 31;
   localparam logic [7:0] SDCR_TEXT_BYTES = 8'h3E;
   localparam logic [7:0] SDCR_MAX_CHARS_B = 8'h1F;
   localparam int SDCR_STORE_BYTES = 186;
   localparam int SDCR_PORT_LO = 1;
   localparam int SDCR_PORT_HI = 4;
   localparam logic [7:0] SDCR_CHARGE_MASK = 8'h1E;
   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] SDCR_LEN_RST = 8'h00;
   localparam logic [7:0] SDCR_CHARGE_RST = 8'h00;
   // string selectors for descriptor fetch
   typedef enum logic [1:0] {SDCR_STR_MAKER, SDCR_STR_PRODUCT, SDCR_STR_SERIAL} sdcr_str_e;
endpackage : sdcr_pkg

// >>> tb/sdcr_cfg_host.sv
/*
 model of the configuring party: eeprom loader or smbus host.
 assumes the bank samples its byte port on the rising edge of ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module sdcr_cfg_host (
   input wire logic ref_clk,
   output logic cfgWrEn,
   output logic cfgRdEn,
   output logic [7:0] cfgAddr,
   output logic [7:0] cfgWrData,
   input wire logic [7:0] cfgRdData,
   input wire logic cfgRdValid
);
   // ---------------------------------------------------------------
   // byte port
   // ---------------------------------------------------------------
   // idle bus at time zero
   initial begin
      cfgWrEn = 1'b0;
      cfgRdEn = 1'b0;
      cfgAddr = 8'h00;
      cfgWrData = 8'h00;
   end
   // one byte write; lines flip once released so stale values never match
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      cfgWrEn <= 1'b1;
      cfgAddr <= a;
      cfgWrData <= d;
      @(posedge ref_clk);
      cfgWrEn <= 1'b0;
      cfgAddr <= ~a;
      cfgWrData <= ~d;
   endtask : wr
   // one byte read; answer taken one cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge ref_clk);
      cfgRdEn <= 1'b1;
      cfgAddr <= a;
      @(posedge ref_clk);
      cfgRdEn <= 1'b0;
      cfgAddr <= ~a;
      @(posedge ref_clk);
      d = cfgRdData;
      v = cfgRdValid;
   endtask : rd
endmodule : sdcr_cfg_host
`default_nettype wire

// >>> tb/sdcr_regs_tb.sv
/*
 self-checking bench of the string and charge enable register bank.
 assumes sdcr_cfg_host for config traffic and a 100 MHz core clock.
*/
`timescale 1ns/10ps
`default_nettype none
module sdcr_regs_tb
   import sdcr_pkg::*;
;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic cfgWrEn, cfgRdEn, cfgRdValid, descStart, descReady, descValid, descLast, descBusy;
   logic [7:0] cfgAddr, cfgWrData, cfgRdData, descData, rdByte;
   logic [1:0] descSel;
   logic [3:0] chargeEnable;
   logic rdOk;
   int nMismatch = 0;
   int checksDone = 0;
   int cycles = 0;
   logic [7:0] vals [6] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'hFF, 8'hE1};
   // ---------------------------------------------------------------
   // clock, instances, watchdog
   // ---------------------------------------------------------------
   always #5 ref_clk = ~ref_clk;
   sdcr_cfg_host host (.ref_clk(ref_clk), .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn),
      .cfgAddr(cfgAddr), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData),
      .cfgRdValid(cfgRdValid));
   sdcr_regs dut (.ref_clk(ref_clk), .rst_b(rst_b), .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn),
      .cfgAddr(cfgAddr), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData),
      .cfgRdValid(cfgRdValid), .descStart(descStart), .descSel(descSel),
      .descReady(descReady), .descValid(descValid), .descData(descData),
      .descLast(descLast), .descBusy(descBusy), .chargeEnable(chargeEnable));
   // hang guard
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         nMismatch++;
         printVerdict();
      end
   end
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // byte j of string s as the writer lays it down
   function automatic logic [7:0] pat(input int s, input int j);
      return 8'(s * 64 + j) ^ 8'hA5;
   endfunction : pat
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checksDone++;
      if (seen !== exp) begin
         nMismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic printVerdict();
      $display("checks %0d mismatches %0d", checksDone, nMismatch);
      if (nMismatch == 0 && checksDone > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : printVerdict
   task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
      host.rd(a, rdByte, rdOk);
      check(rdByte, e);
      check({7'h0, rdOk}, 8'h01);
   endtask : rdChk
   // fetch one string with a stalling consumer and a stray start mid-stream
   task automatic stream(input logic [1:0] sel, input int nb, input int s);
      int k;
      int w;
      k = 0;
      w = 0;
      @(posedge ref_clk);
      descStart <= 1'b1;
      descSel <= sel;
      descReady <= 1'b0;
      while (k < nb && w < 400) begin
         @(posedge ref_clk);
         w++;
         if (descValid === 1'b1 && descReady === 1'b1) begin
            check(descData, pat(s, k));
            check({7'h0, descLast}, {7'h0, k == nb - 1});
            k++;
         end
         descStart <= (w == 2);
         descReady <= w[1];
      end
      repeat (3) @(posedge ref_clk);
      check({7'h0, descValid | descBusy}, 8'h00);
      check(8'(k), 8'(nb));
   endtask : stream
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      descStart = 1'b0;
      descSel = 2'h0;
      descReady = 1'b0;
      repeat (10) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      check({4'h0, chargeEnable}, 8'h00);
      rdChk(SDCR_MAKER_LEN_OFS, 8'h00);
      rdChk(SDCR_CHARGE_EN_OFS, 8'h00);
      // zero length must not start a stream
      @(posedge ref_clk);
      descStart <= 1'b1;
      @(posedge ref_clk);
      descStart <= 1'b0;
      repeat (3) @(posedge ref_clk);
      check({7'h0, descBusy | descValid}, 8'h00);
      $display("test reset done");
      // each port bit alone, then all ones and reserved-only
      foreach (vals[i]) begin
         host.wr(SDCR_CHARGE_EN_OFS, vals[i]);
         @(posedge ref_clk);
         check({4'h0, chargeEnable}, {4'h0, vals[i][4:1]});
         rdChk(SDCR_CHARGE_EN_OFS, vals[i] & 8'h1E);
      end
      host.wr(8'h12, 8'h55);
      rdChk(8'h12, 8'h00);
      rdChk(8'hD1, 8'h00);
      $display("test charge done");
      // three bodies back to back, ascending with no gaps
      for (int j = 0; j < 186; j++) begin
         host.wr(8'h16 + 8'(j), pat(j / 62, j % 62));
      end
      rdChk(8'h53, pat(0, 61));
      rdChk(8'h54, pat(1, 0));
      rdChk(8'h91, pat(1, 61));
      rdChk(8'hCF, pat(2, 61));
      host.wr(SDCR_MAKER_LEN_OFS, 8'h01);
      host.wr(SDCR_PRODUCT_LEN_OFS, 8'h1F);
      host.wr(SDCR_SERIAL_LEN_OFS, 8'h28);
      rdChk(SDCR_SERIAL_LEN_OFS, 8'h28);
      $display("test store done");
      stream(2'h0, 2, 0);
      stream(2'h1, 62, 1);
      stream(2'h2, 62, 2);
      stream(2'h3, 2, 0);
      $display("test stream done");
      printVerdict();
   end
endmodule : sdcr_regs_tb
`default_nettype wire
